// ===== logic/psrd_decoder.sv
// Parallel speed reference decoder: samples the card terminals, decodes
// the reference word and keeps the result for the drive and for software.
// Assumes terminals are asynchronous to pclk and an APB master sets it up.
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module psrd_decoder
  import psrd_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Card terminals
  input wire logic [15:0] ref_data_in,
  input wire logic ref_sign_in,
  input wire logic ref_strobe_in,
  input wire logic word_width_switch,
  // Reference towards the drive
  output logic signed [31:0] freq_ref_value,
  output logic [3:0] freq_ref_unit,
  output logic freq_ref_valid
);

  // ----------------------------------------------------------------
  // Terminal synchronisers
  // ----------------------------------------------------------------
  localparam int PW = $bits(psrd_pins_t);

  psrd_pins_t pins_raw;
  logic [PW-1:0] sync1_ff;
  logic [PW-1:0] sync2_ff;
  logic [PW-1:0] sync3_ff;
  logic [PW-1:0] stable_ff;
  logic [PW-1:0] nxt_stable;
  psrd_pins_t pins;

  assign pins_raw.data = ref_data_in;
  assign pins_raw.sign = ref_sign_in;
  assign pins_raw.strobe = ref_strobe_in;
  assign pins_raw.wide = word_width_switch;

  // Three stages; the first is read only by the second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
    end
    else
    begin
      sync1_ff <= pins_raw;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // A bit changes only once stages two and three agree, so a word
  // caught mid-transition keeps its old bits for one more cycle
  assign nxt_stable = (sync2_ff & sync3_ff) |
                      (stable_ff & (sync2_ff ^ sync3_ff));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stable_ff <= '0;
    else
      stable_ff <= nxt_stable;
  end

  assign pins = psrd_pins_t'(stable_ff);

  // ----------------------------------------------------------------
  // Settings registers
  // ----------------------------------------------------------------
  logic [2:0] fmt_ff;
  logic [1:0] src_ff;
  logic [15:0] scale_ff;
  logic wr_take;
  logic scale_bad;

  // Writes take effect at the edge that completes the access phase
  assign wr_take = psel & penable & pready & pwrite;
  assign scale_bad = (pwdata[15:0] > PSRD_SCALE_MAX) | (|pwdata[31:16]);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fmt_ff <= PSRD_FMT_RST;
      src_ff <= PSRD_SRC_RST;
    end
    else if (wr_take && paddr == PSRD_OFS_CTRL)
    begin
      fmt_ff <= pwdata[PSRD_CTRL_FMT_LSB +: 3];
      src_ff <= pwdata[PSRD_CTRL_SRC_LSB +: 2];
    end
  end

  // Out-of-range scaling is refused so the unit choice stays defined
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      scale_ff <= PSRD_SCALE_RST;
    else if (wr_take && paddr == PSRD_OFS_SCALE && !scale_bad)
      scale_ff <= pwdata[15:0];
  end

  // ----------------------------------------------------------------
  // Reference decode
  // ----------------------------------------------------------------
  psrd_result_t dec;
  logic [15:0] user_fs;
  logic [2:0] user_dp;
  logic [15:0] user_dp_wide;

  // Lower four digits give the full-scale value, fifth the decimals
  assign user_fs = 16'(scale_ff % PSRD_USER_DIGIT_DIV);
  assign user_dp_wide = 16'(scale_ff / PSRD_USER_DIGIT_DIV);
  assign user_dp = user_dp_wide[2:0];

  always_comb
  begin
    logic [3:0] d0;
    logic [3:0] d1;
    logic [3:0] d2;
    logic [3:0] d3;
    logic [3:0] e0;
    logic [1:0] e4;
    logic [15:0] mask;
    logic [15:0] bin;
    logic [31:0] bin_scaled;
    logic [17:0] mag;
    logic use_sign;
    logic bcd_ok;
    logic bcd4_ok;
    logic [17:0] bcd3;
    logic [17:0] bcd4;
    logic [17:0] bcd5;
    d0 = pins.data[3:0];
    d1 = pins.data[7:4];
    d2 = pins.data[11:8];
    d3 = pins.data[15:12];
    // Five-digit mode: lowest digit has no weight-1 line, so it is even
    e0 = {pins.data[2:0], 1'b0};
    e4 = {pins.sign, pins.data[15]};
    mask = pins.wide ? PSRD_MASK_16 : PSRD_MASK_12;
    bin = pins.data & mask;
    bin_scaled = '0;
    mag = '0;
    use_sign = 1'b1;
    dec.unit = psrd_unit_none;
    dec.ok = 1'b1;
    // Nibble digits, three with the narrow switch, four with the wide
    bcd_ok = (d0 <= PSRD_BCD_MAX) && (d1 <= PSRD_BCD_MAX) &&
             (d2 <= PSRD_BCD_MAX);
    bcd4_ok = bcd_ok && (!pins.wide || d3 <= PSRD_BCD_MAX);
    bcd3 = 18'(d0) + 18'(d1) * 18'd10 + 18'(d2) * 18'd100;
    bcd4 = bcd3 + (pins.wide ? 18'(d3) * 18'd1000 : 18'd0);
    bcd5 = 18'(e0) + 18'(pins.data[6:3]) * 18'd10 +
           18'(pins.data[10:7]) * 18'd100 +
           18'(pins.data[14:11]) * 18'd1000 +
           18'(e4) * 18'd10000;
    if (scale_ff >= PSRD_SCALE_RPM_MIN)
    begin
      // Scaling overrides the format: BCD, units from the scaling
      mag = bcd4;
      dec.ok = bcd4_ok;
      if (scale_ff >= PSRD_SCALE_USER_MIN)
        dec.unit = psrd_unit_user;
      else
        dec.unit = psrd_unit_rpm;
    end
    else
    begin
      case (fmt_ff)
        PSRD_FMT_BCD5:
        begin
          // Only meaningful with the wide word; narrow is refused
          use_sign = 1'b0;
          mag = bcd5;
          dec.unit = psrd_unit_hz_0p01;
          dec.ok = pins.wide && (e0 <= PSRD_BCD_MAX) &&
                   (pins.data[6:3] <= PSRD_BCD_MAX) &&
                   (pins.data[10:7] <= PSRD_BCD_MAX) &&
                   (pins.data[14:11] <= PSRD_BCD_MAX);
        end
        PSRD_FMT_BINARY:
        begin
          if (bin == mask)
            mag = PSRD_BIN_FULL;
          else
          begin
            if (pins.wide)
              bin_scaled = 32'(bin) / PSRD_BIN16_DIV;
            else
              bin_scaled = (32'(bin) * 32'd10000) / PSRD_BIN12_DIV;
            mag = bin_scaled[17:0];
          end
          dec.unit = psrd_unit_bin_0p01pct;
        end
        default:
        begin
          mag = bcd4;
          dec.ok = bcd4_ok;
          case (fmt_ff)
            3'h0: dec.unit = psrd_unit_pct_1;
            3'h1: dec.unit = psrd_unit_pct_0p1;
            3'h2: dec.unit = psrd_unit_pct_0p01;
            3'h3: dec.unit = psrd_unit_hz_1;
            3'h4: dec.unit = psrd_unit_hz_0p1;
            default: dec.unit = psrd_unit_hz_0p01;
          endcase
        end
      endcase
    end
    // Sign line: high means reverse, except in five-digit mode where it is the top digit bit
    if (use_sign && pins.sign)
      dec.value = -$signed(32'(mag));
    else
      dec.value = $signed(32'(mag));
  end

  // ----------------------------------------------------------------
  // Capture and hold
  // ----------------------------------------------------------------
  logic signed [31:0] value_ff;
  logic [3:0] unit_ff;
  logic have_ff;
  logic fault_ff;
  logic valid_ff;

  // Strobe high reads the word every cycle; low holds the last result.
  // A bad word is not taken, so the drive never sees a torn value.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      value_ff <= '0;
      unit_ff <= 4'(psrd_unit_none);
      have_ff <= 1'b0;
    end
    else if (pins.strobe && dec.ok)
    begin
      value_ff <= dec.value;
      unit_ff <= 4'(dec.unit);
      have_ff <= 1'b1;
    end
  end

  // Fault reflects the most recent read attempt
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fault_ff <= 1'b0;
    else if (pins.strobe)
      fault_ff <= !dec.ok;
  end

  // The drive uses the card only when the source selects it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      valid_ff <= 1'b0;
    else
      valid_ff <= have_ff && (src_ff == PSRD_SRC_OPTION_CARD);
  end

  assign freq_ref_value = value_ff;
  assign freq_ref_unit = unit_ff;
  assign freq_ref_valid = valid_ff;

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] rd_mux;
  logic setup;
  logic mapped;

  // Answer is prepared in the setup cycle so outputs come from flops;
  // costs nothing since pready is high in the first access cycle
  assign setup = psel & !penable;
  assign mapped = (paddr == PSRD_OFS_CTRL) || (paddr == PSRD_OFS_SCALE) ||
                  (paddr == PSRD_OFS_REF) || (paddr == PSRD_OFS_STATUS) ||
                  (paddr == PSRD_OFS_USER);

  always_comb
  begin
    rd_mux = '0;
    case (paddr)
      PSRD_OFS_CTRL:
      begin
        rd_mux[PSRD_CTRL_FMT_LSB +: 3] = fmt_ff;
        rd_mux[PSRD_CTRL_SRC_LSB +: 2] = src_ff;
      end
      PSRD_OFS_SCALE: rd_mux[15:0] = scale_ff;
      PSRD_OFS_REF: rd_mux = value_ff;
      PSRD_OFS_STATUS:
      begin
        rd_mux[PSRD_STAT_UNIT_LSB +: 4] = unit_ff;
        rd_mux[PSRD_STAT_WIDE_BIT] = pins.wide;
        rd_mux[PSRD_STAT_STROBE_BIT] = pins.strobe;
        rd_mux[PSRD_STAT_FAULT_BIT] = fault_ff;
        rd_mux[PSRD_STAT_VALID_BIT] = valid_ff;
        rd_mux[PSRD_STAT_HAVE_BIT] = have_ff;
      end
      PSRD_OFS_USER:
      begin
        rd_mux[15:0] = user_fs;
        rd_mux[18:16] = user_dp;
      end
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_ff <= '0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      pready_ff <= setup;
      prdata_ff <= (setup && !pwrite) ? rd_mux : '0;
      pslverr_ff <= setup && (!mapped ||
                    (pwrite && (paddr == PSRD_OFS_REF ||
                                paddr == PSRD_OFS_STATUS ||
                                paddr == PSRD_OFS_USER)) ||
                    (pwrite && paddr == PSRD_OFS_SCALE && scale_bad));
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

endmodule // psrd_decoder

`default_nettype wire

// ===== shared/psrd_pkg.sv
// Package for the parallel speed reference decoder.
// Assumes one 10 MHz clock and an APB master that owns the register space.
package psrd_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] PSRD_OFS_CTRL = 8'h00;
  localparam logic [7:0] PSRD_OFS_SCALE = 8'h04;
  localparam logic [7:0] PSRD_OFS_REF = 8'h08;
  localparam logic [7:0] PSRD_OFS_STATUS = 8'h0c;
  localparam logic [7:0] PSRD_OFS_USER = 8'h10;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int PSRD_CTRL_FMT_LSB = 0;
  localparam int PSRD_CTRL_SRC_LSB = 4;
  localparam logic [2:0] PSRD_FMT_RST = 3'h0;
  localparam logic [1:0] PSRD_SRC_RST = 2'h0;
  localparam logic [15:0] PSRD_SCALE_RST = 16'h0000;
  localparam int PSRD_STAT_UNIT_LSB = 0;
  localparam int PSRD_STAT_WIDE_BIT = 4;
  localparam int PSRD_STAT_STROBE_BIT = 5;
  localparam int PSRD_STAT_FAULT_BIT = 6;
  localparam int PSRD_STAT_VALID_BIT = 7;
  localparam int PSRD_STAT_HAVE_BIT = 8;

  // ----------------------------------------------------------------
  // Setting values
  // ----------------------------------------------------------------
  localparam logic [1:0] PSRD_SRC_OPTION_CARD = 2'h3;
  localparam logic [2:0] PSRD_FMT_BCD5 = 3'h6;
  localparam logic [2:0] PSRD_FMT_BINARY = 3'h7;
  localparam logic [15:0] PSRD_SCALE_RPM_MIN = 16'h0002;
  localparam logic [15:0] PSRD_SCALE_USER_MIN = 16'h0028; // 40
  localparam logic [15:0] PSRD_SCALE_MAX = 16'h9c3f; // 39999
  localparam logic [15:0] PSRD_USER_DIGIT_DIV = 16'h2710; // 10000
  localparam logic [17:0] PSRD_BIN_FULL = 18'h02710; // 100.00 % in 0.01 %
  localparam logic [15:0] PSRD_MASK_12 = 16'h0fff;
  localparam logic [15:0] PSRD_MASK_16 = 16'hffff;
  localparam logic [31:0] PSRD_BIN12_DIV = 32'h00000fff; // 4095 counts
  localparam logic [31:0] PSRD_BIN16_DIV = 32'h00000003; // 30000 / 10000
  localparam logic [3:0] PSRD_BCD_MAX = 4'h9;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    psrd_unit_pct_1,
    psrd_unit_pct_0p1,
    psrd_unit_pct_0p01,
    psrd_unit_hz_1,
    psrd_unit_hz_0p1,
    psrd_unit_hz_0p01,
    psrd_unit_bin_0p01pct,
    psrd_unit_rpm,
    psrd_unit_user,
    psrd_unit_none
  } psrd_unit_t;

  typedef struct packed {
    logic [15:0] data;
    logic sign;
    logic strobe;
    logic wide;
  } psrd_pins_t;

  typedef struct packed {
    logic signed [31:0] value;
    psrd_unit_t unit;
    logic ok;
  } psrd_result_t;

endpackage

// ===== testbench/psrd_card_model.sv
// Card-side model: drives word, sign and read strobe.
// Assumes the bench holds load high for as long as a read lasts.
`timescale 1ns/1ps
`default_nettype none
module psrd_card_model
  import psrd_pkg::*;
(
  // Clock
  input wire logic pclk,
  // Bench request
  input wire logic load,
  input wire logic [15:0] word,
  input wire logic sgn,
  input wire logic wide,
  // Card terminals
  output var psrd_pins_t pins
);
  // Lines toggle once released, so stale data can never pass as held
  always_ff @(posedge pclk)
  begin
    pins.wide <= wide;
    if (load)
    begin
      pins.data <= word;
      pins.sign <= sgn;
      pins.strobe <= 1'b1;
    end
    else if (pins.strobe !== 1'b0) // Unknown at start settles low
      pins.strobe <= 1'b0;
    else
    begin
      pins.data <= ~pins.data;
      pins.sign <= ~pins.sign;
    end
  end
endmodule // psrd_card_model
`default_nettype wire

// ===== testbench/psrd_decoder_properties.sv
// Checker on the decoder ports: APB timing, refusals, capture, hold.
// Assumes one clock domain; bound to every decoder instance.
`timescale 1ns/1ps
`default_nettype none
module psrd_checker
  import psrd_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Strobe and result
  input wire logic ref_strobe_in,
  input wire logic signed [31:0] freq_ref_value,
  input wire logic [3:0] freq_ref_unit,
  input wire logic freq_ref_valid
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completing write access
  logic wr_end;
  assign wr_end = psel && penable && pready && pwrite;
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready too long");
  setup_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  ctrl_write_a: assert property (
    wr_end && paddr == PSRD_OFS_CTRL |-> !pslverr)
    else $error("format write refused");
  scale_bad_a: assert property (
    wr_end && paddr == PSRD_OFS_SCALE
    && pwdata > {16'h0, PSRD_SCALE_MAX} |-> pslverr)
    else $error("scaling over range taken");
  scale_ok_a: assert property (
    wr_end && paddr == PSRD_OFS_SCALE
    && pwdata <= {16'h0, PSRD_SCALE_MAX} |-> !pslverr)
    else $error("scaling in range refused");
  ref_hold_a: assert property (
    (!ref_strobe_in) [*6] |=> $stable(freq_ref_value)
    && $stable(freq_ref_unit))
    else $error("reference moved without strobe");
  capture_cause_a: assert property (
    $changed(freq_ref_value) |-> $past(ref_strobe_in, 2)
    || $past(ref_strobe_in, 3) || $past(ref_strobe_in, 4)
    || $past(ref_strobe_in, 5) || $past(ref_strobe_in, 6))
    else $error("reference changed without read");
  valid_unit_a: assert property (
    freq_ref_valid |-> freq_ref_unit != 4'h9)
    else $error("valid without unit");
  cover property (wr_end && pslverr);
  cover property ($rose(freq_ref_valid));
  cover property (freq_ref_value < 0);
endmodule // psrd_checker
bind psrd_decoder psrd_checker u_psrd_checker (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ref_strobe_in(ref_strobe_in),
  .freq_ref_value(freq_ref_value), .freq_ref_unit(freq_ref_unit),
  .freq_ref_valid(freq_ref_valid));
`default_nettype wire

// ===== testbench/test_parallel_speed_reference_decoder.sv
// Bench for the decoder: APB set-up, card words, decoded results.
// Assumes the card model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module test_parallel_speed_reference_decoder;
  import psrd_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic load = 1'b0;
  logic [15:0] word = 16'h0;
  logic sgn = 1'b0;
  logic wide = 1'b1;
  psrd_pins_t pins;
  logic signed [31:0] rv;
  logic [3:0] ru;
  logic rok;
  logic [31:0] rd;
  logic er;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  // 10 MHz clock
  always #50 pclk = ~pclk;
  psrd_decoder u_psrd_decoder (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ref_data_in(pins.data),
    .ref_sign_in(pins.sign), .ref_strobe_in(pins.strobe),
    .word_width_switch(pins.wide), .freq_ref_value(rv),
    .freq_ref_unit(ru), .freq_ref_valid(rok));
  psrd_card_model u_psrd_card_model (.pclk(pclk), .load(load),
    .word(word), .sgn(sgn), .wide(wide), .pins(pins));
  task automatic complete_run();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // A hang counts as a mismatch
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s,
    input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One APB transfer; waits for pready, only the timeout ends a hang
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Format, option-card source and scaling
  task automatic cfg(input logic [2:0] f, input logic [15:0] sc);
    apb(1'b1, PSRD_OFS_CTRL, {26'h0, 2'h3, 1'b0, f});
    apb(1'b1, PSRD_OFS_SCALE, {16'h0, sc});
  endtask
  // Strobe a word in, check it, release and check it holds
  task automatic put(input logic [15:0] d, input logic s,
    input logic [31:0] ev, input logic [3:0] eu);
    @(posedge pclk);
    word <= d;
    sgn <= s;
    load <= 1'b1;
    repeat (8) @(posedge pclk);
    load <= 1'b0;
    chk("value", rv, ev);
    chk("unit", {28'h0, ru}, {28'h0, eu});
    repeat (8) @(posedge pclk);
    chk("held", rv, ev);
  endtask
  task automatic t_regs();
    apb(1'b0, PSRD_OFS_CTRL, 32'h0);
    chk("ctrl reset", rd, 32'h0);
    apb(1'b0, PSRD_OFS_STATUS, 32'h0);
    chk("status reset", rd & 32'h8f, 32'h9);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", {31'h0, er}, 32'h1);
    apb(1'b1, PSRD_OFS_REF, 32'h5);
    chk("ro write", {31'h0, er}, 32'h1);
    $display("regs done");
  endtask
  task automatic t_bcd();
    for (int f = 0; f < 6; f++)
    begin
      cfg(f[2:0], 16'h0);
      put(16'h1234 + f[15:0], f[0], f[0] ? -(1234 + f) : 1234 + f,
        f[3:0]);
    end
    wide <= 1'b0;
    put(16'hf987, 1'b0, 32'd987, 4'h5);
    put(16'h01a3, 1'b0, 32'd987, 4'h5);
    apb(1'b0, PSRD_OFS_STATUS, 32'h0);
    chk("digit fault", {31'h0, rd[6]}, 32'h1);
    $display("bcd done");
  endtask
  task automatic t_bin();
    cfg(3'h7, 16'h0);
    wide <= 1'b1;
    put(16'hffff, 1'b0, 32'd10000, 4'h6);
    put(16'h7530, 1'b1, -10000, 4'h6);
    wide <= 1'b0;
    put(16'h0fff, 1'b0, 32'd10000, 4'h6);
    put(16'hf800, 1'b1, -5001, 4'h6);
    $display("binary done");
  endtask
  task automatic t_bcd5();
    cfg(3'h6, 16'h0);
    wide <= 1'b1;
    put(16'h91a2, 1'b1, 32'd32344, 4'h5);
    wide <= 1'b0;
    put(16'h0000, 1'b0, 32'd32344, 4'h5);
    apb(1'b0, PSRD_OFS_STATUS, 32'h0);
    chk("narrow fault", {31'h0, rd[6]}, 32'h1);
    $display("five digit done");
  endtask
  task automatic t_scale();
    wide <= 1'b1;
    cfg(3'h7, 16'd20);
    put(16'h0321, 1'b1, -321, 4'h7);
    cfg(3'h7, 16'd21234);
    put(16'h0456, 1'b0, 32'd456, 4'h8);
    apb(1'b0, PSRD_OFS_USER, 32'h0);
    chk("user", rd, 32'h000204d2);
    apb(1'b1, PSRD_OFS_SCALE, 32'd40000);
    chk("scale refused", {31'h0, er}, 32'h1);
    apb(1'b0, PSRD_OFS_SCALE, 32'h0);
    chk("scale kept", rd, 32'd21234);
    $display("scaling done");
  endtask
  task automatic t_src();
    apb(1'b1, PSRD_OFS_CTRL, 32'h7);
    apb(1'b0, PSRD_OFS_STATUS, 32'h0);
    chk("other source", {31'h0, rok}, 32'h0);
    chk("status other", {31'h0, rd[7]}, 32'h0);
    cfg(3'h7, 16'h0);
    apb(1'b0, PSRD_OFS_STATUS, 32'h0);
    chk("card source", {31'h0, rok}, 32'h1);
    chk("status valid", {31'h0, rd[7]}, 32'h1);
    $display("source done");
  endtask
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_bcd();
    t_bin();
    t_bcd5();
    t_scale();
    t_src();
    complete_run();
  end
endmodule // test_parallel_speed_reference_decoder
`default_nettype wire
